// ==== hdl/carry_adder.sv ====
// 8-bit adder with carry in and carry out
`timescale 1ns/1ps
module carry_adder (
   alu_if.alu a
);
   logic [8:0] full;
   assign full = {1'b0, a.opA} + {1'b0, a.opB} + {8'h00, a.carryIn};
   assign a.sum = full[7:0];
   assign a.carryOut = full[8];
endmodule

// ==== hdl/script_alu_carry.sv ====
// script processor carry, notify, operand and residual-byte execution logic
//
// Behaviour
// RULE1 - odd-ending chained move holds last byte, pairs it with next move's first byte
// RULE2 - instruction with bit 20 set raises status bit 2 after execution
// RULE3 - notify does not halt; execution carries on with next instruction
// RULE4 - reading interrupt status is the only way to clear the notify bit
// RULE5 - jump/call/return/interrupt can branch on carry, selected by bit 21
// RULE6 - carry condition with data compare is illegal; treated as no branch
// RULE7 - command byte bit 0 adds current carry into add result
// RULE8 - use-received option takes operand from first byte received register
// RULE9 - io instruction with bit 10 sets or clears carry as encoded
// RULE10 - every add loads carry with its sum's carry out
// RULE11 - carry holds between instructions; reset clears it
`timescale 1ns/1ps
`include "script_alu_consts.svh"
module script_alu_carry (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // status to the host
   output logic notifyFlag,
   output logic carryFlag,
   output logic branchTaken,
   output logic [15:0] wideWord,
   output logic wideValid
);
   logic [31:0] instrHi_q, instrLo_q;
   logic [7:0] firstByteRecv_q, regOperand_q;
   logic [7:0] result_q, moveByte_q, residual_q;
   logic residualValid_q, carry_q, notify_q, branch_q;
   logic [15:0] wide_q;
   logic wideValid_q, execGo_q, movePending_q;
   logic [2:0] moveCtrl_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   script_alu_pkg::exec_e state_q;
   logic wrAcc, rdAcc, doneExec, ifly;
   logic [1:0] instrClass;
   alu_if alu ();

   carry_adder adder (
      .a(alu.alu)
   );

   function automatic logic isMapped(input logic [7:0] addr);
      isMapped = (addr <= `ADDR_CTRL) && (addr[1:0] == 2'h0);
   endfunction

   // writes land only at the edge where the master sees pready
   assign wrAcc = psel && penable && pwrite && pready_q;
   assign rdAcc = psel && penable && !pwrite && !pready_q;
   assign instrClass = instrHi_q[`FLD_CLASS_HI:`FLD_CLASS_LO];
   assign doneExec = state_q == script_alu_pkg::EXEC_RUN;

   // operand substitution: received byte replaces the immediate byte
   assign alu.opA = regOperand_q;
   assign alu.opB = instrHi_q[`BIT_USE_RECV] ? firstByteRecv_q : instrLo_q[`FLD_BYTE_HI:`FLD_BYTE_LO]; // [RULE8]
   assign alu.carryIn = instrHi_q[`BIT_CARRY_EN] && carry_q; // [RULE7]

   // one-cycle wait state so every access answers in the second access cycle
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !isMapped(paddr);
         if (rdAcc) begin
            unique case (paddr)
               `ADDR_INSTR_HI: prdata_q <= instrHi_q;
               `ADDR_INSTR_LO: prdata_q <= instrLo_q;
               `ADDR_OPS: prdata_q <= {16'h0000, firstByteRecv_q, regOperand_q};
               `ADDR_IRQ_STATUS: prdata_q <= {29'h0000_0000, notify_q, 2'h0};
               `ADDR_RESULT: prdata_q <= {22'h00_0000, branch_q, carry_q, result_q};
               `ADDR_MOVE: prdata_q <= {20'h0_0000, residualValid_q, moveCtrl_q, moveByte_q};
               `ADDR_WIDE: prdata_q <= {15'h0000, wideValid_q, wide_q};
               `ADDR_CTRL: prdata_q <= {30'h0000_0000, movePending_q, state_q != script_alu_pkg::EXEC_IDLE};
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // software writes of instruction words and operands
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         instrHi_q <= 32'h0000_0000;
         instrLo_q <= 32'h0000_0000;
         firstByteRecv_q <= 8'h00;
         regOperand_q <= 8'h00;
         moveByte_q <= 8'h00;
         moveCtrl_q <= 3'h0;
      end else if (wrAcc) begin
         if (paddr == `ADDR_INSTR_HI) instrHi_q <= pwdata;
         if (paddr == `ADDR_INSTR_LO) instrLo_q <= pwdata;
         if (paddr == `ADDR_OPS) begin
            regOperand_q <= pwdata[`FLD_BYTE_HI:`FLD_BYTE_LO];
            firstByteRecv_q <= pwdata[`FLD_RECV_HI:`FLD_RECV_LO];
         end
         if (paddr == `ADDR_MOVE) begin
            moveByte_q <= pwdata[`FLD_BYTE_HI:`FLD_BYTE_LO];
            moveCtrl_q <= pwdata[`FLD_MOVE_CTRL_HI:`FLD_MOVE_CTRL_LO];
         end
      end
   end

   // start strobes for instruction execution and move bytes
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         execGo_q <= 1'b0;
         movePending_q <= 1'b0;
      end else begin
         execGo_q <= wrAcc && paddr == `ADDR_CTRL && pwdata[`BIT_GO];
         movePending_q <= wrAcc && paddr == `ADDR_MOVE;
      end
   end

   // sequencer never stalls on notify, it just returns to idle
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= script_alu_pkg::EXEC_IDLE;
      end else begin
         unique case (state_q)
            script_alu_pkg::EXEC_IDLE: if (execGo_q) state_q <= script_alu_pkg::EXEC_RUN;
            script_alu_pkg::EXEC_RUN: state_q <= script_alu_pkg::EXEC_DONE;
            script_alu_pkg::EXEC_DONE: state_q <= script_alu_pkg::EXEC_IDLE; // [RULE3]
         endcase
      end
   end

   // carry: add loads carry out, io sets/clears, else holds
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         carry_q <= 1'b0; // [RULE11]
         result_q <= 8'h00;
      end else if (doneExec) begin
         if (instrClass == `CLASS_RW && instrHi_q[`BIT_DO_ADD]) begin
            carry_q <= alu.carryOut; // [RULE10]
            result_q <= alu.sum; // [RULE7]
         end else if (instrClass == `CLASS_IO && instrLo_q[`BIT_CARRY_IO]) begin
            carry_q <= instrLo_q[`BIT_CARRY_VAL]; // [RULE9]
         end
      end
   end

   // branch on carry; compare combined with carry is illegal, never branches
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         branch_q <= 1'b0;
      end else if (doneExec && instrClass == `CLASS_XFER) begin
         branch_q <= instrLo_q[`BIT_CARRY_COND] ?
            (!instrLo_q[`BIT_COMPARE] && (carry_q == instrLo_q[`BIT_WANT_TRUE])) : 1'b1; // [RULE5] [RULE6]
      end
   end

   // notify flag: set wins over the clearing status read
   assign ifly = doneExec && instrLo_q[`BIT_NOTIFY];
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         notify_q <= 1'b0;
      end else if (ifly) begin
         notify_q <= 1'b1; // [RULE2]
      end else if (rdAcc && paddr == `ADDR_IRQ_STATUS) begin
         notify_q <= 1'b0; // [RULE4]
      end
   end

   // residual byte merge across chained moves
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         residual_q <= 8'h00;
         residualValid_q <= 1'b0;
         wide_q <= 16'h0000;
         wideValid_q <= 1'b0;
      end else begin
         wideValid_q <= 1'b0;
         if (movePending_q) begin
            if (residualValid_q) begin
               wide_q <= {moveByte_q, residual_q}; // [RULE1]
               wideValid_q <= 1'b1;
               residualValid_q <= 1'b0;
            end else if (moveCtrl_q[`BIT_CHAINED] && moveCtrl_q[`BIT_ODD]) begin
               residual_q <= moveByte_q; // [RULE1]
               residualValid_q <= 1'b1;
            end
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign notifyFlag = notify_q;
   assign carryFlag = carry_q;
   assign branchTaken = branch_q;
   assign wideWord = wide_q;
   assign wideValid = wideValid_q;

   // assertions
   notify_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE2]
      ifly |=> notifyFlag) else $error("notify flag not set after notify instruction");
   notify_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE4]
      notifyFlag && !(rdAcc && paddr == `ADDR_IRQ_STATUS) |=> notifyFlag)
      else $error("notify flag cleared without status read");
   no_halt_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE3]
      doneExec |=> ##1 state_q == script_alu_pkg::EXEC_IDLE) else $error("sequencer stalled");
   carry_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE11]
      !doneExec |=> $stable(carryFlag)) else $error("carry changed without instruction");
   carry_add_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE10]
      doneExec && instrClass == `CLASS_RW && instrHi_q[`BIT_DO_ADD] |=> carryFlag == $past(alu.carryOut))
      else $error("carry not loaded from add");
   carry_io_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE9]
      doneExec && instrClass == `CLASS_IO && instrLo_q[`BIT_CARRY_IO]
      |=> carryFlag == $past(instrLo_q[`BIT_CARRY_VAL]))
      else $error("carry not set or cleared by io");
   illegal_cmp_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE6]
      doneExec && instrClass == `CLASS_XFER && instrLo_q[`BIT_CARRY_COND] && instrLo_q[`BIT_COMPARE] |=> !branchTaken)
      else $error("illegal carry compare branched");
   branch_carry_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE5]
      doneExec && instrClass == `CLASS_XFER && instrLo_q[`BIT_CARRY_COND] && !instrLo_q[`BIT_COMPARE]
      |=> branchTaken == ($past(carry_q) == $past(instrLo_q[`BIT_WANT_TRUE])))
      else $error("carry branch wrong");
   carry_in_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE7]
      doneExec && instrClass == `CLASS_RW && instrHi_q[`BIT_DO_ADD]
      |=> {carryFlag, result_q} == 9'($past(regOperand_q)) + 9'($past(alu.opB))
         + 9'($past(instrHi_q[`BIT_CARRY_EN] && carry_q)))
      else $error("add result ignores carry in");
   operand_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE8]
      instrHi_q[`BIT_USE_RECV] |-> alu.opB == firstByteRecv_q) else $error("operand not received byte");
   residual_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE1]
      movePending_q && residualValid_q |=> wideValid && wideWord[7:0] == $past(residual_q))
      else $error("residual byte not paired");
endmodule

// ==== include/alu_if.sv ====
// carrier between the executor and the adder
`timescale 1ns/1ps
interface alu_if;
   logic [7:0] opA;
   logic [7:0] opB;
   logic carryIn;
   logic [7:0] sum;
   logic carryOut;
   modport exec (output opA, output opB, output carryIn, input sum, input carryOut);
   modport alu (input opA, input opB, input carryIn, output sum, output carryOut);
endinterface

// ==== include/script_alu_consts.svh ====
// offsets, field positions and class codes for the script alu extension block
`ifndef SCRIPT_ALU_CONSTS_SVH
`define SCRIPT_ALU_CONSTS_SVH
`define ADDR_INSTR_HI 8'h00
`define ADDR_INSTR_LO 8'h04
`define ADDR_OPS 8'h08
`define ADDR_IRQ_STATUS 8'h0c
`define ADDR_RESULT 8'h10
`define ADDR_MOVE 8'h14
`define ADDR_WIDE 8'h18
`define ADDR_CTRL 8'h1c
`define BIT_NOTIFY 20
`define BIT_CARRY_COND 21
`define BIT_CARRY_IO 10
`define BIT_CARRY_VAL 9
`define BIT_CARRY_EN 0
`define BIT_USE_RECV 1
`define BIT_IFLY_STATUS 2
`define BIT_DO_ADD 2
`define BIT_COMPARE 18
`define BIT_WANT_TRUE 19
`define FLD_CLASS_HI 7
`define FLD_CLASS_LO 6
`define CLASS_RW 2'h1
`define CLASS_XFER 2'h2
`define CLASS_IO 2'h3
`define CLASS_MOVE 2'h0
`define BIT_CHAINED 2
`define BIT_ODD 0
`define BIT_GO 0
`define FLD_BYTE_HI 7
`define FLD_BYTE_LO 0
`define FLD_RECV_HI 15
`define FLD_RECV_LO 8
`define FLD_MOVE_CTRL_HI 10
`define FLD_MOVE_CTRL_LO 8
`endif

// ==== include/script_alu_pkg.sv ====
// shared types for the script alu extension block
package script_alu_pkg;
   typedef enum logic [1:0] {
      EXEC_IDLE,
      EXEC_RUN,
      EXEC_DONE
   } exec_e;
endpackage

// ==== verif/host_model.sv ====
// host processor model: apb master that services the notify status by reading it
`timescale 1ns/1ps
module host_model (
   // clock
   input wire logic ref_clk,
   // apb request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   // apb answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // held until pready is seen at an edge; a read of the status is the host's only acknowledge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // no cycle count assumed: only the bench watchdog ends a hung wait
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ==== verif/script_alu_carry_tb.sv ====
// self-checking bench for the carry, notify and residual-byte logic
`timescale 1ns/1ps
`include "script_alu_consts.svh"
module script_alu_carry_tb;
   logic refClk, rstB, psel, penable, pwrite, pready, pslverr;
   logic notifyFlag, carryFlag, branchTaken, wideValid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] wideWord;
   int miscompares = 0;
   int nTests = 0;
   initial begin
      refClk = 1'b0;
      rstB = 1'b0;
   end
   always #10 refClk = ~refClk;
   host_model hostU (.ref_clk(refClk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   script_alu_carry dut_u (.ref_clk(refClk), .rst_b(rstB), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .notifyFlag(notifyFlag), .carryFlag(carryFlag), .branchTaken(branchTaken), .wideWord(wideWord),
      .wideValid(wideValid));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      hostU.xfer(1'b1, a, d, r, e);
   endtask
   // results settle two cycles after the start write lands; six leaves margin
   task automatic exec(input logic [7:0] hi, input logic [31:0] lo, input logic [15:0] ops);
      wr(`ADDR_OPS, {16'h0, ops});
      wr(`ADDR_INSTR_HI, {24'h0, hi});
      wr(`ADDR_INSTR_LO, lo);
      wr(`ADDR_CTRL, 32'h1);
      repeat (6) @(posedge refClk);
   endtask
   task automatic carry_io_test;
      check("carry after reset", carryFlag, 32'h0);
      exec(8'hc0, 32'h600, 16'h0);
      check("carry set", carryFlag, 32'h1);
      repeat (10) @(posedge refClk);
      check("carry held", carryFlag, 32'h1);
      exec(8'hc0, 32'h400, 16'h0);
      check("carry cleared", carryFlag, 32'h0);
   endtask
   task automatic add_test;
      logic [31:0] r;
      logic e;
      exec(8'h44, 32'h20, 16'h00f0);
      hostU.xfer(1'b0, `ADDR_RESULT, 32'h0, r, e);
      check("sum", {23'h0, r[8:0]}, 32'h110);
      check("carry out", carryFlag, 32'h1);
      exec(8'h45, 32'h01, 16'h0001);
      hostU.xfer(1'b0, `ADDR_RESULT, 32'h0, r, e);
      check("sum with carry in", {23'h0, r[8:0]}, 32'h003);
      exec(8'h46, 32'h05, 16'h807f);
      hostU.xfer(1'b0, `ADDR_RESULT, 32'h0, r, e);
      check("received operand", {23'h0, r[8:0]}, 32'h0ff);
   endtask
   task automatic branch_test;
      for (int c = 0; c < 2; c++) begin
         for (int w = 0; w < 2; w++) begin
            exec(8'hc0, 32'h400 | (32'(c) << 9), 16'h0);
            exec(8'h80, 32'h200000 | (32'(w) << 19), 16'h0);
            check("carry branch", branchTaken, {31'h0, c == w});
         end
      end
      // carry condition mixed with a compare must never branch
      exec(8'h80, 32'h2c0000, 16'h0);
      check("illegal mix", branchTaken, 32'h0);
   endtask
   task automatic notify_test;
      logic [31:0] r;
      logic e;
      exec(8'hc0, 32'h100600, 16'h0);
      check("notify raised", notifyFlag, 32'h1);
      exec(8'hc0, 32'h400, 16'h0);
      check("runs on after notify", carryFlag, 32'h0);
      check("notify kept", notifyFlag, 32'h1);
      hostU.xfer(1'b0, `ADDR_IRQ_STATUS, 32'h0, r, e);
      check("status bit", {31'h0, r[2]}, 32'h1);
      repeat (2) @(posedge refClk);
      check("notify serviced", notifyFlag, 32'h0);
      hostU.xfer(1'b0, `ADDR_IRQ_STATUS, 32'h0, r, e);
      check("status after read", {31'h0, r[2]}, 32'h0);
      hostU.xfer(1'b0, 8'h20, 32'h0, r, e);
      check("unmapped error", {31'h0, e}, 32'h1);
      check("unmapped data", r, 32'h0);
   endtask
   task automatic move_test;
      int n;
      wr(`ADDR_MOVE, 32'h5aa);
      wr(`ADDR_MOVE, 32'h055);
      n = 0;
      while (wideValid !== 1'b1 && n < 6) begin
         @(posedge refClk);
         n++;
      end
      check("wide pulse", {31'h0, wideValid}, 32'h1);
      check("wide word", {16'h0, wideWord}, 32'h55aa);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge refClk);
      rstB <= 1'b1;
      carry_io_test();
      add_test();
      branch_test();
      notify_test();
      move_test();
      test_done();
   end
   // whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge refClk);
      miscompares++;
      test_done();
   end
endmodule
